// ==== hw/srm_filter.sv ====
`timescale 1ns/1ps
// Qualifies a level: high once input has stood high for LIMIT cycles
module srm_filter #(
   parameter int LIMIT = 8,
   parameter int W = 24
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Level in, qualified level and run time out
   input wire logic lvlIn,
   output logic qual,
   output logic [W-1:0] runTime
);
   logic [W-1:0] cnt_r, cnt_nxt;
   logic qual_r, qual_nxt;

   // ======================================================
   // Saturating run counter; restarts when level drops
   always_comb begin
      cnt_nxt = cnt_r;
      qual_nxt = qual_r;
      if (!lvlIn) begin
         cnt_nxt = '0;
         qual_nxt = 1'b0;
      end else if (cnt_r != {W{1'b1}}) begin
         cnt_nxt = cnt_r + 1'b1;
         if (cnt_nxt >= W'(LIMIT)) begin
            qual_nxt = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_r <= '0;
         qual_r <= 1'b0;
      end else if (ce) begin
         cnt_r <= cnt_nxt;
         qual_r <= qual_nxt;
      end
   end

   assign qual = qual_r;
   assign runTime = cnt_r;
endmodule

// ==== hw/srm_pkg.sv ====
package srm_pkg;
   // ======================================================
   // Register map (byte addresses)
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_FLAGS = 8'h08;
   localparam logic [7:0] ADDR_MASK = 8'h0C;
   localparam logic [7:0] ADDR_DOMAIN = 8'h10;
   localparam logic [7:0] ADDR_CFG6 = 8'h14;
   // ======================================================
   // Field positions
   localparam int CFG6_UV_DIS = 3;
   localparam int CTRL_RELATCH_EN = 0;
   localparam int CTRL_PWL_DIS = 1;
   localparam int FLG_CRANK = 0;
   localparam int FLG_BATOV = 1;
   localparam int FLG_RELATCH = 2;
   localparam int FLG_LONGUV = 3;
   localparam int NUM_FLAGS = 4;
   // Reset values
   localparam logic [31:0] CTRL_RST = 32'h0000_0002;
   localparam logic [31:0] CFG6_RST = 32'h0000_0000;
   // ======================================================
   // Timing, 200 MHz clock
   localparam int CLK_MHZ = 200;
   localparam int IO_FILT_MIN_US = 3;
   localparam int IO_FILT_CYC = IO_FILT_MIN_US * CLK_MHZ;
   localparam int EXT_FILT_US = 5;
   localparam int EXT_FILT_CYC = EXT_FILT_US * CLK_MHZ;
   localparam int UV_FILT_US = 10;
   localparam int UV_FILT_CYC = UV_FILT_US * CLK_MHZ;
   localparam int UV_REL_US = 1000;
   localparam int UV_REL_CYC = UV_REL_US * CLK_MHZ;
   localparam int HOLD_US = 1000;
   localparam int HOLD_CYC = HOLD_US * CLK_MHZ;
   localparam int RELATCH_US = 1000;
   localparam int RELATCH_CYC = RELATCH_US * CLK_MHZ;
   localparam int OV1_US = 20;
   localparam int OV1_CYC = OV1_US * CLK_MHZ;
   localparam int OV2_US = 1000;
   localparam int OV2_CYC = OV2_US * CLK_MHZ;
   localparam int CNT_W = 24;
   // ======================================================
   // Reset sequencer states
   typedef enum logic [2:0] {
      ST_RUN = 3'b001,
      ST_HOLD = 3'b010,
      ST_RELEASE = 3'b100
   } srm_state_e;
endpackage

// ==== hw/srm_smart_reset.sv ====
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module srm_smart_reset
   import srm_pkg::*;
#(
   parameter int UV_FILT = UV_FILT_CYC,
   parameter int UV_REL = UV_REL_CYC,
   parameter int HOLD = HOLD_CYC,
   parameter int RELATCH = RELATCH_CYC,
   parameter int OV1 = OV1_CYC,
   parameter int OV2 = OV2_CYC
) (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Reset line toward host
   input wire logic rstLineIn,
   output logic rstLineOut,
   output logic rstLineOe,
   // Asynchronous sources from comparators and pins
   input wire logic main5vLow,
   input wire logic main5vHigh,
   input wire logic ioSupplyLow,
   input wire logic batteryOv,
   input wire logic ignitionKey,
   input wire logic powerDown,
   input wire logic watchdogReset,
   // Domain resets and power manager commands
   output logic coreRst,
   output logic lowBatRst,
   output logic driversOff,
   output logic powerOff,
   output logic outputsDisabled,
   output logic irq
);
   // ======================================================
   // Input synchronisers
   localparam int NSYNC = 7;
   // Reset to idle pin levels: line high, all sources quiet, so no
   // false power down or key edge reaches the sequencer after reset
   localparam logic [NSYNC-1:0] SYNC_IDLE = 7'h40;
   logic [NSYNC-1:0] syncA_r, syncB_r, rawIn;
   assign rawIn = {rstLineIn, main5vLow, main5vHigh, ioSupplyLow,
                   batteryOv, ignitionKey, powerDown};
   always_ff @(posedge clk) begin
      if (rst) begin
         syncA_r <= SYNC_IDLE;
         syncB_r <= SYNC_IDLE;
      end else if (ce) begin
         syncA_r <= rawIn;
         syncB_r <= syncA_r;
      end
   end
   logic lineS, uvS, okS, ioS, ovS, keyS, pdS;
   assign {lineS, uvS, okS, ioS, ovS, keyS, pdS} = syncB_r;

   // ======================================================
   // Registers
   logic [31:0] ctrl_r, ctrl_nxt, cfg6_r, cfg6_nxt;
   logic [NUM_FLAGS-1:0] flags_r, flags_nxt, mask_r, mask_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
   logic key_r, ever5v_r, ever5v_nxt;
   logic outDis_r, outDis_nxt;
   logic uvEn, uvLvl, extLvl, keyRise, relatchHit;
   logic uvQ, ioQ, extQ, ov1Q, ov2Q;
   logic [CNT_W-1:0] uvRun, extRun;
   srm_state_e state_r, state_nxt;
   logic [CNT_W-1:0] tmr_r, tmr_nxt;
   logic longHold_r, longHold_nxt;
   logic hostRst;
   logic rstLineOut_r, rstLineOut_nxt;

   assign uvEn = !cfg6_r[CFG6_UV_DIS];
   // no 5 V since start also counts as undervoltage
   assign uvLvl = uvEn && (uvS || !ever5v_r);
   // Own drive excluded so the line does not latch itself
   assign extLvl = !lineS && !rstLineOut_r;

   // ======================================================
   // Filters on each qualified source
   srm_filter #(.LIMIT(UV_FILT), .W(CNT_W)) uUvFilt (
      .clk(clk), .rst(rst), .ce(ce),
      .lvlIn(uvLvl), .qual(uvQ), .runTime(uvRun));
   srm_filter #(.LIMIT(IO_FILT_CYC), .W(CNT_W)) uIoFilt (
      .clk(clk), .rst(rst), .ce(ce),
      .lvlIn(ioS), .qual(ioQ), .runTime());
   srm_filter #(.LIMIT(EXT_FILT_CYC), .W(CNT_W)) uExtFilt (
      .clk(clk), .rst(rst), .ce(ce),
      .lvlIn(extLvl), .qual(extQ), .runTime(extRun));
   // Both overvoltage windows watch one level, each with its own count
   // Their run times are not needed, so those outputs stay open
   srm_filter #(.LIMIT(OV1), .W(CNT_W)) uOv1Filt (
      .clk(clk), .rst(rst), .ce(ce),
      .lvlIn(ovS), .qual(ov1Q), .runTime());
   srm_filter #(.LIMIT(OV2), .W(CNT_W)) uOv2Filt (
      .clk(clk), .rst(rst), .ce(ce),
      .lvlIn(ovS), .qual(ov2Q), .runTime());

   // key_r resets low like the idle pin, so reset gives no false edge
   // Key edge; relatch only in power latch with enable set
   assign keyRise = keyS && !key_r;
   assign relatchHit = keyRise && ever5v_r && ctrl_r[CTRL_RELATCH_EN]
                       && !ctrl_r[CTRL_PWL_DIS];

   // ======================================================
   // Reset sequencer: hold, then timed release
   always_comb begin
      state_nxt = state_r;
      tmr_nxt = tmr_r;
      longHold_nxt = longHold_r;
      case (state_r)
         ST_RUN: begin
            tmr_nxt = '0;
            if (pdS || uvQ || ioQ || ov2Q || watchdogReset) begin
               state_nxt = ST_HOLD;
            end else if (relatchHit) begin
               state_nxt = ST_RELEASE;
               tmr_nxt = CNT_W'(RELATCH);
            end
         end
         ST_HOLD: begin
            if (!(pdS || uvQ || ioQ || ov2Q || watchdogReset)) begin
               state_nxt = ST_RELEASE;
               tmr_nxt = CNT_W'(UV_REL);
            end
         end
         ST_RELEASE: begin
            // A new source during release restarts the hold
            if (pdS || uvQ || ioQ || ov2Q || watchdogReset) begin
               state_nxt = ST_HOLD;
            end else if (tmr_r <= CNT_W'(1)) begin
               state_nxt = ST_RUN;
            end else begin
               tmr_nxt = tmr_r - 1'b1;
            end
         end
         default: begin
            // Illegal code falls back to holding reset
            state_nxt = ST_HOLD;
            tmr_nxt = '0;
         end
      endcase
      // Long 5 V or external dip also resets low battery logic
      if (state_nxt == ST_RUN && !extQ) begin
         longHold_nxt = 1'b0;
      end else if (uvRun >= CNT_W'(HOLD) || extRun >= CNT_W'(HOLD)
                   || pdS || ov2Q || relatchHit) begin
         longHold_nxt = 1'b1;
      end
      rstLineOut_nxt = (state_nxt != ST_RUN);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= ST_HOLD;
         tmr_r <= '0;
         longHold_r <= 1'b1;
         rstLineOut_r <= 1'b1;
      end else if (ce) begin
         state_r <= state_nxt;
         tmr_r <= tmr_nxt;
         longHold_r <= longHold_nxt;
         rstLineOut_r <= rstLineOut_nxt;
      end
   end

   // Internal reset covers own assertion and filtered outside low
   assign hostRst = rstLineOut_r || extQ;

   // ======================================================
   // Registers, flags and APB; flags survive host reset
   logic apbAcc, apbWr, apbRd;
   logic [NUM_FLAGS-1:0] setEv, clrWr;
   // Registered answer costs one wait state but keeps pready clean
   assign apbAcc = psel && penable && !pready_r;
   assign apbWr = apbAcc && pwrite;
   assign apbRd = apbAcc && !pwrite;

   always_comb begin
      setEv = '0;
      setEv[FLG_CRANK] = uvQ && !pdS;
      setEv[FLG_BATOV] = ov1Q;
      setEv[FLG_RELATCH] = relatchHit;
      setEv[FLG_LONGUV] = uvRun >= CNT_W'(HOLD) && !pdS;
      clrWr = '0;
      if (apbWr && paddr == ADDR_STATUS) begin
         clrWr = pwdata[NUM_FLAGS-1:0];
      end
      ctrl_nxt = ctrl_r;
      cfg6_nxt = cfg6_r;
      mask_nxt = mask_r;
      ever5v_nxt = ever5v_r || okS;
      outDis_nxt = outDis_r;
      if (apbWr && paddr == ADDR_CTRL) begin
         ctrl_nxt = pwdata;
      end
      if (apbWr && paddr == ADDR_CFG6) begin
         cfg6_nxt = pwdata;
      end
      if (apbWr && paddr == ADDR_MASK) begin
         mask_nxt = pwdata[NUM_FLAGS-1:0];
      end
      if (apbWr && paddr == ADDR_DOMAIN) begin
         outDis_nxt = pwdata[0];
      end
      if (hostRst) begin
         cfg6_nxt = CFG6_RST;
         outDis_nxt = 1'b1;
      end
      if (pdS) begin
         ctrl_nxt = CTRL_RST;
      end
      // Read of flags clears them; set in same cycle wins
      flags_nxt = flags_r & ~clrWr;
      if (apbRd && paddr == ADDR_FLAGS) begin
         flags_nxt = '0;
      end
      flags_nxt = flags_nxt | setEv;
      prdata_nxt = prdata_r;
      pslverr_nxt = 1'b0;
      pready_nxt = apbAcc;
      if (apbAcc) begin
         prdata_nxt = '0;
         case (paddr)
            ADDR_CTRL: prdata_nxt = ctrl_r;
            ADDR_STATUS: prdata_nxt = 32'(flags_r);
            ADDR_FLAGS: prdata_nxt = 32'(flags_r);
            ADDR_MASK: prdata_nxt = 32'(mask_r);
            ADDR_DOMAIN: prdata_nxt = {27'h0, state_r, longHold_r,
                                       outDis_r};
            ADDR_CFG6: prdata_nxt = cfg6_r;
            default: pslverr_nxt = 1'b1;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_r <= CTRL_RST;
         cfg6_r <= CFG6_RST;
         mask_r <= '0;
         flags_r <= '0;
         ever5v_r <= 1'b0;
         outDis_r <= 1'b1;
         key_r <= 1'b0;
         prdata_r <= '0;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end else if (ce) begin
         ctrl_r <= ctrl_nxt;
         cfg6_r <= cfg6_nxt;
         mask_r <= mask_nxt;
         flags_r <= flags_nxt;
         ever5v_r <= ever5v_nxt;
         outDis_r <= outDis_nxt;
         key_r <= keyS;
         prdata_r <= prdata_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   // ======================================================
   // Domain outputs, all registered so no decode glitch reaches a pin
   logic coreRst_r, lowBatRst_r, drvOff_r, pwrOff_r, irq_r, lineOe_r;
   logic coreRst_nxt, lowBatRst_nxt, drvOff_nxt, pwrOff_nxt, irq_nxt;
   logic lineOe_nxt;
   // Next values; line enable follows the sequencer's next state
   always_comb begin
      coreRst_nxt = hostRst;
      // Low battery logic only while longHold_r is set, not on every host reset
      lowBatRst_nxt = hostRst && longHold_r;
      // Mid overvoltage drops drivers but keeps configuration
      drvOff_nxt = hostRst || ov1Q;
      pwrOff_nxt = pdS;
      // A set mask bit hides its flag from the interrupt
      irq_nxt = |(flags_r & ~mask_r);
      // Enable low pulls the line, on the same edge as the state change
      lineOe_nxt = !rstLineOut_nxt;
   end

   // Register only; reset holds every domain in reset
   always_ff @(posedge clk) begin
      if (rst) begin
         coreRst_r <= 1'b1;
         lowBatRst_r <= 1'b1;
         drvOff_r <= 1'b1;
         pwrOff_r <= 1'b0;
         irq_r <= 1'b0;
         lineOe_r <= 1'b0;
      end else if (ce) begin
         coreRst_r <= coreRst_nxt;
         lowBatRst_r <= lowBatRst_nxt;
         drvOff_r <= drvOff_nxt;
         pwrOff_r <= pwrOff_nxt;
         irq_r <= irq_nxt;
         lineOe_r <= lineOe_nxt;
      end
   end

   // Open-drain data is always low; only the enable moves
   assign rstLineOut = 1'b0;
   assign rstLineOe = lineOe_r; // low enable drives low
   assign coreRst = coreRst_r;
   assign lowBatRst = lowBatRst_r;
   assign driversOff = drvOff_r;
   assign powerOff = pwrOff_r;
   assign outputsDisabled = outDis_r;
   assign irq = irq_r;
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
endmodule

// ==== test/srm_host_model.sv ====
`timescale 1ns/1ps
// ==========================================
// Host side of the shared reset line
module srm_host_model (
   // Device drive, open drain
   input wire logic rstLineOut,
   input wire logic rstLineOe,
   // Host sinks the line
   input wire logic hostHold,
   // Wire level seen by all
   output logic lineLvl
);
   // Pull-up wins unless a party sinks the line
   assign lineLvl = !((!rstLineOe && !rstLineOut) || hostHold);
endmodule

// ==== test/srm_smart_reset_properties.sv ====
`timescale 1ns/1ps
// ==========================================
// Port checks for the reset manager
module srm_checker
   import srm_pkg::*;
#(
   parameter int UV_REL = UV_REL_CYC,
   parameter int OV1 = OV1_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Bus handshake
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   // Line and sources
   input wire logic rstLineOut,
   input wire logic rstLineOe,
   input wire logic main5vHigh,
   input wire logic ioSupplyLow,
   input wire logic batteryOv,
   input wire logic powerDown,
   input wire logic watchdogReset,
   // Domain outputs
   input wire logic coreRst,
   input wire logic lowBatRst,
   input wire logic driversOff,
   input wire logic powerOff,
   input wire logic outputsDisabled
);
   int ioCnt_r, ovCnt_r, hiCnt_r, ioCnt_nxt, ovCnt_nxt, hiCnt_nxt;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Run lengths; the run is short, so no wrap
   always_comb begin
      ioCnt_nxt = ioSupplyLow ? ioCnt_r + 1 : 0;
      ovCnt_nxt = batteryOv ? ovCnt_r + 1 : 0;
      hiCnt_nxt = main5vHigh ? hiCnt_r + 1 : 0;
   end
   // Counter registers
   always_ff @(posedge clk) begin
      if (rst) begin
         ioCnt_r <= 0;
         ovCnt_r <= 0;
         hiCnt_r <= 0;
      end else begin
         ioCnt_r <= ioCnt_nxt;
         ovCnt_r <= ovCnt_nxt;
         hiCnt_r <= hiCnt_nxt;
      end
   end
   // ==========================================
   // Assertions
   AST_PREADY_ANSWER:
      assert property (ce && psel && penable && !pready |=> pready)
      else $error("no pready after access");
   AST_PREADY_PULSE:
      assert property (pready |=> !pready) else $error("pready too long");
   AST_SLVERR_WITH_READY:
      assert property (pslverr |-> pready) else $error("lone pslverr");
   AST_LINE_LOW:
      assert property (!rstLineOe |-> !rstLineOut)
      else $error("line driven high");
   AST_RESET_STATE:
      assert property (disable iff (1'b0)
         rst |=> !rstLineOe && coreRst && outputsDisabled)
      else $error("bad state after reset");
   AST_CORE_FOLLOWS:
      assert property (!rstLineOe |-> ##[0:3] coreRst)
      else $error("core not in reset");
   AST_PD_LINE:
      assert property ($rose(powerDown) |-> ##[1:8] !rstLineOe)
      else $error("power down slow");
   AST_PD_DOMAIN:
      assert property ($rose(powerDown) |-> ##[1:8] powerOff && lowBatRst)
      else $error("power down domains");
   AST_WD_LINE:
      assert property ($rose(watchdogReset) |-> ##[1:8] !rstLineOe)
      else $error("watchdog no reset");
   AST_IO_LINE:
      assert property (ioCnt_r == 620 |-> !rstLineOe)
      else $error("io undervoltage no reset");
   AST_OV_DRIVERS:
      assert property (ovCnt_r == OV1 + 8 |-> driversOff)
      else $error("drivers still on");
   AST_RELEASE_DELAY:
      assert property ($rose(rstLineOe) |-> hiCnt_r >= UV_REL)
      else $error("early release");
endmodule

// ==== test/test_srm_smart_reset.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
   bad_count++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); \
   end end
// ==========================================
// Bench for the reset manager
module test_srm_smart_reset
   import srm_pkg::*;
();
   localparam int UF = 20, UR = 40, HD = 80, RL = 30, O1 = 20, O2 = 60;
   logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, hostHold = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, e, lineLvl, rstLineOut, rstLineOe;
   logic main5vLow = 1, main5vHigh = 0, ioSupplyLow = 0, batteryOv = 0;
   logic ignitionKey = 0, powerDown = 0, watchdogReset = 0;
   logic coreRst, lowBatRst, driversOff, powerOff, outputsDisabled, irq;
   int bad_count = 0, cmp_count = 0;
   // 200 MHz clock
   always #2.5 clk = ~clk;
   // Short counts keep the run brief
   srm_smart_reset #(.UV_FILT(UF), .UV_REL(UR), .HOLD(HD), .RELATCH(RL),
      .OV1(O1), .OV2(O2)) i_dut (.clk, .rst, .ce(1'b1), .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .rstLineIn(lineLvl), .rstLineOut, .rstLineOe, .main5vLow,
      .main5vHigh, .ioSupplyLow, .batteryOv, .ignitionKey, .powerDown,
      .watchdogReset, .coreRst, .lowBatRst, .driversOff, .powerOff,
      .outputsDisabled, .irq);
   srm_host_model i_host (.rstLineOut, .rstLineOe, .hostHold, .lineLvl);
   // ==========================================
   // Verdict and end of run
   task automatic end_sim();
      if (bad_count == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // One bus transfer; holds until pready seen at an edge
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      // Sample pready, data and error at the rising edge itself
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         bad_count++;
         end_sim();
      end
      repeat (2) @(negedge clk);
   endtask
   // Read and compare data and error
   task automatic rd(input logic [7:0] a, input logic [31:0] x,
      input logic se);
      apb(1'b0, a, 32'h0);
      `CHK("read data", x, q)
      `CHK("slave error", se, e)
   endtask
   // Bounded wait for the line drive state
   task automatic waitOe(input logic v, input int lim);
      int n;
      @(negedge clk);
      for (n = 0; rstLineOe !== v; n++) begin
         if (n == lim) begin
            bad_count++;
            end_sim();
         end
         @(negedge clk);
      end
   endtask
   // Line drive must not move for a stretch
   task automatic stayOe(input logic v, input int cyc);
      logic ok;
      ok = 1'b1;
      repeat (cyc) begin
         @(negedge clk);
         ok &= (rstLineOe === v);
      end
      `CHK("line hold", 1'b1, ok)
   endtask
   // Both 5 V comparators move together
   task automatic uvSet(input logic v);
      @(posedge clk);
      main5vLow <= v;
      main5vHigh <= !v;
   endtask
   // ==========================================
   // Main sequence
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk) ignitionKey <= 1'b1;
      stayOe(1'b0, HD + 10);
      uvSet(1'b0);
      stayOe(1'b0, UR - 5);
      waitOe(1'b1, 40);
      repeat (4) @(negedge clk);
      `CHK("core", 1'b0, coreRst)
      `CHK("outdis", 1'b1, outputsDisabled)
      rd(ADDR_CTRL, CTRL_RST, 1'b0);
      rd(ADDR_CFG6, CFG6_RST, 1'b0);
      rd(ADDR_FLAGS, 32'h9, 1'b0);
      rd(8'hFC, 32'h0, 1'b1);
      // Mid overvoltage, unmasked, then masked
      apb(1'b1, ADDR_MASK, 32'h0);
      @(posedge clk) batteryOv <= 1'b1;
      stayOe(1'b1, O1 + 15);
      `CHK("drv off", 1'b1, driversOff)
      `CHK("irq", 1'b1, irq)
      @(posedge clk) batteryOv <= 1'b0;
      rd(ADDR_STATUS, 32'h2, 1'b0);
      apb(1'b1, ADDR_STATUS, 32'h2);
      `CHK("irq", 1'b0, irq)
      apb(1'b1, ADDR_MASK, 32'h2);
      @(posedge clk) batteryOv <= 1'b1;
      stayOe(1'b1, O1 + 15);
      `CHK("irq", 1'b0, irq)
      @(posedge clk) batteryOv <= 1'b0;
      repeat (4) @(negedge clk); // Let the overvoltage filter fall
      rd(ADDR_FLAGS, 32'h2, 1'b0);
      rd(ADDR_FLAGS, 32'h0, 1'b0);
      @(posedge clk) batteryOv <= 1'b1;
      waitOe(1'b0, O2 + 20);
      @(posedge clk) batteryOv <= 1'b0;
      waitOe(1'b1, UR + 100);
      rd(ADDR_FLAGS, 32'h2, 1'b0);
      // Short then long 5 V undervoltage
      apb(1'b1, ADDR_DOMAIN, 32'h0);
      `CHK("outdis", 1'b0, outputsDisabled)
      uvSet(1'b1);
      waitOe(1'b0, UF + 10);
      repeat (HD / 2) @(negedge clk);
      `CHK("lb spared", 1'b0, lowBatRst)
      uvSet(1'b0);
      stayOe(1'b0, UR - 5);
      waitOe(1'b1, 60);
      `CHK("outdis", 1'b1, outputsDisabled)
      rd(ADDR_FLAGS, 32'h1, 1'b0);
      rd(ADDR_FLAGS, 32'h0, 1'b0);
      uvSet(1'b1);
      repeat (HD + 30) @(negedge clk);
      `CHK("lb reset", 1'b1, lowBatRst)
      uvSet(1'b0);
      waitOe(1'b1, UR + 60);
      rd(ADDR_FLAGS, 32'h9, 1'b0);
      // Undervoltage source switched off
      apb(1'b1, ADDR_CFG6, 32'h8);
      uvSet(1'b1);
      stayOe(1'b1, UF + 30);
      uvSet(1'b0);
      rd(ADDR_FLAGS, 32'h0, 1'b0);
      // I/O supply: not before 3 us, then reset
      @(posedge clk) ioSupplyLow <= 1'b1;
      stayOe(1'b1, 590);
      waitOe(1'b0, 40);
      repeat (30) @(negedge clk);
      @(posedge clk) ioSupplyLow <= 1'b0;
      waitOe(1'b1, UR + 60);
      // Watchdog pulse
      @(posedge clk) watchdogReset <= 1'b1;
      @(posedge clk) watchdogReset <= 1'b0;
      waitOe(1'b0, 10);
      waitOe(1'b1, UR + 60);
      // Host holds the line: short is ignored, long resets
      @(posedge clk) hostHold <= 1'b1;
      repeat (900) @(negedge clk);
      `CHK("core", 1'b0, coreRst)
      repeat (150) @(negedge clk);
      `CHK("core", 1'b1, coreRst)
      `CHK("power", 1'b0, powerOff)
      @(posedge clk) hostHold <= 1'b0;
      waitOe(1'b1, UR + 60);
      repeat (UR + 20) @(negedge clk);
      rd(ADDR_FLAGS, 32'h0, 1'b0);
      // Key toggle in power latch mode
      apb(1'b1, ADDR_CTRL, 32'h1);
      @(posedge clk) ignitionKey <= 1'b0;
      repeat (4) @(posedge clk);
      ignitionKey <= 1'b1;
      waitOe(1'b0, 20);
      stayOe(1'b0, RL - 10);
      waitOe(1'b1, UR + RL + 60);
      `CHK("power", 1'b0, powerOff)
      rd(ADDR_FLAGS, 32'h4, 1'b0);
      // Power down ends the run
      @(posedge clk) powerDown <= 1'b1;
      waitOe(1'b0, 8);
      repeat (3) @(negedge clk);
      `CHK("power", 1'b1, powerOff)
      `CHK("lb", 1'b1, lowBatRst)
      end_sim();
   end
endmodule
bind srm_smart_reset srm_checker #(.UV_REL(UV_REL), .OV1(OV1)) i_chk (
   .clk, .rst, .ce, .psel, .penable, .pready, .pslverr, .rstLineOut,
   .rstLineOe, .main5vHigh, .ioSupplyLow, .batteryOv, .powerDown,
   .watchdogReset, .coreRst, .lowBatRst, .driversOff, .powerOff,
   .outputsDisabled);
